//--- spf_pkg.sv
package spf_pkg;

    // Framing constants
    localparam logic [7:0] SYNC_HI = 8'hAA;
    localparam logic [7:0] SYNC_LO = 8'hBB;
    localparam logic [7:0] SCRAMBLE_DEFAULT = 8'hA5;
    localparam logic [7:0] FILL_DEFAULT = 8'h55;
    localparam logic [7:0] TYPE_DATA = 8'h01;
    localparam logic [7:0] TYPE_FILLER = 8'h09;
    localparam logic [7:0] TYPE_NULL = 8'h09;
    localparam int RETX_BIT = 5;
    localparam logic [7:0] BUNDLES_SUGGESTED = 8'h0F;
    localparam logic [4:0] SYNC_LAST = 5'h01;
    localparam logic [4:0] OLDEST_LAST = 5'h03;
    localparam logic [4:0] BUNDLE_LAST = 5'h10;
    localparam logic [4:0] CRC_LAST = 5'h01;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [15:0] CRC_POLY = 16'h8408;

    // Command packets
    localparam int CMD_BODY = 26;
    localparam logic [4:0] CMD_CRC_LAST = 5'h1B;
    localparam logic [7:0] CMD_RETX_LIST = 8'h01;
    localparam logic [7:0] CMD_RETX_RANGE = 8'h02;
    localparam logic [7:0] CMD_CALIB = 8'h06;

    // Bundle sample limits and rate codes
    localparam logic [4:0] SAMPLES_MIN = 5'h04;
    localparam logic [4:0] SAMPLES_MAX = 5'h10;
    localparam logic [4:0] RATE_MIN = 5'h01;
    localparam logic [4:0] RATE_MAX = 5'h10;

    typedef struct packed {
        logic retransmit;
        logic [31:0] oldest;
        logic [31:0] seconds;
        logic [15:0] subSeconds;
        logic [4:0] modelType;
        logic [10:0] serial;
        logic [31:0] seqNum;
        logic [4:0] rateCode;
        logic [2:0] channel;
        logic [23:0] firstSample;
    } spf_hdr_s;

    typedef enum logic [1:0] {
        CMD_UNKNOWN = 2'h0,
        CMD_LIST = 2'h1,
        CMD_RANGE = 2'h2,
        CMD_CAL = 2'h3
    } spf_cmd_e;

    typedef struct packed {
        spf_cmd_e kind;
        logic [15:0] instId;
        logic [31:0] seconds;
        logic [7:0] pktType;
        logic [7:0] channel;
        logic [15:0] spare;
        logic [127:0] data;
    } spf_cmd_s;

    // Reflected CCITT, one byte, lsb first
    function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // Header bundle, type byte in the low byte, fields lsb first
    function automatic logic [135:0] hdrBytes(input spf_hdr_s h);
        logic [7:0] typ;
        typ = TYPE_DATA;
        typ[RETX_BIT] = h.retransmit;
        return {h.firstSample, h.rateCode, h.channel, h.seqNum, h.modelType, h.serial,
                h.subSeconds, h.seconds, typ};
    endfunction

    function automatic logic [4:0] setSamples(input logic [1:0] code);
        unique case (code)
            2'b00: return 5'h00;
            2'b01: return 5'h04;
            2'b10: return 5'h02;
            2'b11: return 5'h01;
        endcase
    endfunction

endpackage

//--- spf_skid.sv
`timescale 1ns/1ps
module spf_skid #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData
);
    logic skValid_q;
    logic [W-1:0] skData_q;
    logic accept;
    logic moveOut;

    assign accept = inValid && inReady;
    assign moveOut = !outValid || outReady;

    // Second entry catches the word in flight when the drain side stalls
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outValid <= 1'b0;
            outData <= '0;
            skValid_q <= 1'b0;
            skData_q <= '0;
            inReady <= 1'b1;
        end else if (moveOut && skValid_q) begin
            outValid <= 1'b1;
            outData <= skData_q;
            skValid_q <= 1'b0;
            inReady <= 1'b1;
        end else if (moveOut) begin
            outValid <= accept;
            if (accept) begin
                outData <= inData;
            end
            inReady <= 1'b1;
        end else if (accept) begin
            skValid_q <= 1'b1;
            skData_q <= inData;
            inReady <= 1'b0;
        end
    end
endmodule

//--- spf_framer.sv
`timescale 1ns/1ps
module spf_framer #(
    parameter logic [7:0] SCRAMBLE_VALUE = spf_pkg::SCRAMBLE_DEFAULT,
    parameter logic [7:0] FILL_VALUE = spf_pkg::FILL_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] bundleCount,
    input wire logic hdrValid,
    output logic hdrReady,
    input wire spf_pkg::spf_hdr_s hdr,
    input wire logic bunValid,
    output logic bunReady,
    input wire logic [7:0] bunData,
    input wire logic bunLast,
    output logic txValid,
    input wire logic txReady,
    output logic [7:0] txData,
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    output logic cmdValid,
    output spf_pkg::spf_cmd_s cmd,
    output logic cmdCrcBad,
    output logic bundleBad,
    output logic rateBad
);
    typedef enum logic [4:0] {
        TX_SYNC = 5'b00001,
        TX_OLD = 5'b00010,
        TX_HEAD = 5'b00100,
        TX_BODY = 5'b01000,
        TX_CRC = 5'b10000
    } spf_tx_e;

    typedef enum logic [2:0] {
        RX_HUNT1 = 3'b001,
        RX_HUNT2 = 3'b010,
        RX_BODY = 3'b100
    } spf_rx_e;

    spf_tx_e txSt_q;
    logic [4:0] idx_q;
    logic [7:0] bunIdx_q;
    logic [7:0] nBund_q;
    logic isData_q;
    logic pad_q;
    logic [15:0] crc_q;
    logic hdrHeld_q;
    spf_pkg::spf_hdr_s hdrBuf_q;
    spf_pkg::spf_hdr_s cur_q;
    logic [135:0] hdrVec;
    logic [7:0] raw;
    logic canEmit;
    logic take;
    logic emit;
    logic txInReady;
    logic startPkt;
    logic secLast;
    logic bsValid;
    logic bsLast;
    logic [7:0] bsData;
    logic [7:0] fillerType;
    logic [4:0] samples;

    // Input side: bundle bytes pass a two-entry buffer so bunReady is a flop
    spf_skid #(.W(9)) inBuf (
        .clk(clk),
        .rst_n(rst_n),
        .inValid(bunValid),
        .inReady(bunReady),
        .inData({bunLast, bunData}),
        .outValid(bsValid),
        .outReady(take),
        .outData({bsLast, bsData})
    );

    // Output side: receiver stalls on txReady without losing a byte
    spf_skid #(.W(8)) outBuf (
        .clk(clk),
        .rst_n(rst_n),
        .inValid(canEmit),
        .inReady(txInReady),
        .inData(raw ^ SCRAMBLE_VALUE),
        .outValid(txValid),
        .outReady(txReady),
        .outData(txData)
    );

    assign hdrVec = spf_pkg::hdrBytes(cur_q);
    assign emit = canEmit && txInReady;
    assign startPkt = emit && (txSt_q == TX_SYNC) && (idx_q == 5'h00);

    always_comb begin
        fillerType = spf_pkg::TYPE_FILLER;
        fillerType[spf_pkg::RETX_BIT] = 1'b0;
    end

    // Byte to send in the present slot, before scrambling
    always_comb begin
        raw = 8'h00;
        canEmit = 1'b1;
        take = 1'b0;
        secLast = 1'b0;
        unique case (txSt_q)
            TX_SYNC: begin
                raw = idx_q[0] ? spf_pkg::SYNC_LO : spf_pkg::SYNC_HI;
                secLast = (idx_q == spf_pkg::SYNC_LAST);
            end
            TX_OLD: begin
                raw = 8'(cur_q.oldest >> {idx_q[1:0], 3'b000});
                secLast = (idx_q == spf_pkg::OLDEST_LAST);
            end
            TX_HEAD: begin
                if (isData_q) begin
                    raw = 8'(hdrVec >> {idx_q, 3'b000});
                end else begin
                    raw = (idx_q == 5'h00) ? fillerType : FILL_VALUE;
                end
                secLast = (idx_q == spf_pkg::BUNDLE_LAST);
            end
            TX_BODY: begin
                if (!isData_q) begin
                    raw = FILL_VALUE;
                end else if (pad_q) begin
                    raw = (idx_q == 5'h00) ? spf_pkg::TYPE_NULL : FILL_VALUE;
                end else begin
                    raw = bsData;
                    canEmit = bsValid;
                    take = bsValid && txInReady;
                end
                secLast = (idx_q == spf_pkg::BUNDLE_LAST);
            end
            TX_CRC: begin
                raw = idx_q[0] ? crc_q[15:8] : crc_q[7:0];
                secLast = (idx_q == spf_pkg::CRC_LAST);
            end
        endcase
    end

    // Packet sequencing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txSt_q <= TX_SYNC;
            idx_q <= 5'h00;
            bunIdx_q <= 8'h00;
        end else if (emit) begin
            idx_q <= secLast ? 5'h00 : idx_q + 5'h01;
            if (secLast) begin
                unique case (txSt_q)
                    TX_SYNC: txSt_q <= TX_OLD;
                    TX_OLD: txSt_q <= TX_HEAD;
                    TX_HEAD: begin
                        txSt_q <= TX_BODY;
                        bunIdx_q <= 8'h00;
                    end
                    TX_BODY: begin
                        bunIdx_q <= bunIdx_q + 8'h01;
                        if (bunIdx_q == nBund_q - 8'h01) begin
                            txSt_q <= TX_CRC;
                        end
                    end
                    TX_CRC: txSt_q <= TX_SYNC;
                endcase
            end
        end
    end

    // Odd bundle count, zero falls back to the suggested count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nBund_q <= spf_pkg::BUNDLES_SUGGESTED;
        end else if (startPkt) begin
            nBund_q <= (bundleCount == 8'h00) ? spf_pkg::BUNDLES_SUGGESTED : (bundleCount | 8'h01);
        end
    end

    // Data packet when a header waits, filler packet otherwise
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            isData_q <= 1'b0;
            cur_q <= '0;
        end else if (startPkt) begin
            isData_q <= hdrHeld_q;
            if (hdrHeld_q) begin
                cur_q <= hdrBuf_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hdrHeld_q <= 1'b0;
            hdrReady <= 1'b1;
            hdrBuf_q <= '0;
        end else if (hdrValid && hdrReady) begin
            hdrHeld_q <= 1'b1;
            hdrReady <= 1'b0;
            hdrBuf_q <= hdr;
        end else if (startPkt && hdrHeld_q) begin
            hdrHeld_q <= 1'b0;
            hdrReady <= 1'b1;
        end
    end

    // Once the source marks its last byte the rest of that bundle is FILL_VALUE and later bundles are null bundles
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pad_q <= 1'b0;
        end else if (startPkt) begin
            pad_q <= 1'b0;
        end else if (take && bsLast) begin
            pad_q <= 1'b1;
        end
    end

    // CRC over unscrambled bytes, frozen while it is being sent
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            crc_q <= spf_pkg::CRC_INIT;
        end else if (startPkt) begin
            crc_q <= spf_pkg::crcByte(spf_pkg::CRC_INIT, raw);
        end else if (emit && txSt_q != TX_CRC) begin
            crc_q <= spf_pkg::crcByte(crc_q, raw);
        end
    end

    // Sample count of a source bundle from its set codes
    always_comb begin
        samples = spf_pkg::setSamples(bsData[7:6]) + spf_pkg::setSamples(bsData[5:4])
                + spf_pkg::setSamples(bsData[3:2]) + spf_pkg::setSamples(bsData[1:0]);
    end

    // Null bundles from the source are passed on, not checked
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bundleBad <= 1'b0;
            rateBad <= 1'b0;
        end else begin
            bundleBad <= take && idx_q == 5'h00 && bsData != spf_pkg::TYPE_NULL
                      && (samples < spf_pkg::SAMPLES_MIN || samples > spf_pkg::SAMPLES_MAX);
            rateBad <= hdrValid && hdrReady
                    && (hdr.rateCode < spf_pkg::RATE_MIN || hdr.rateCode > spf_pkg::RATE_MAX);
        end
    end

    // Command receiver
    spf_rx_e rxSt_q;
    logic [4:0] rxIdx_q;
    logic [15:0] rxCrc_q;
    logic [7:0] rxBuf_q [spf_pkg::CMD_BODY];
    logic [7:0] rb;
    logic [15:0] rxCrcNext;
    logic [127:0] dataSec;
    spf_pkg::spf_cmd_e kind;

    assign rb = rxData ^ SCRAMBLE_VALUE;
    assign rxCrcNext = spf_pkg::crcByte((rxSt_q == RX_HUNT1) ? spf_pkg::CRC_INIT : rxCrc_q, rb);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxSt_q <= RX_HUNT1;
            rxIdx_q <= 5'h00;
            rxCrc_q <= spf_pkg::CRC_INIT;
        end else if (rxValid) begin
            rxCrc_q <= rxCrcNext;
            unique case (rxSt_q)
                RX_HUNT1: if (rb == spf_pkg::SYNC_HI) begin
                    rxSt_q <= RX_HUNT2;
                end
                RX_HUNT2: begin
                    rxSt_q <= (rb == spf_pkg::SYNC_LO) ? RX_BODY : RX_HUNT1;
                    rxIdx_q <= 5'h00;
                end
                RX_BODY: begin
                    rxIdx_q <= rxIdx_q + 5'h01;
                    if (rxIdx_q == spf_pkg::CMD_CRC_LAST) begin
                        rxSt_q <= RX_HUNT1;
                    end
                end
            endcase
        end
    end

    for (genvar i = 0; i < spf_pkg::CMD_BODY; i++) begin : gRxByte
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                rxBuf_q[i] <= 8'h00;
            end else if (rxValid && rxSt_q == RX_BODY && rxIdx_q == 5'(i)) begin
                rxBuf_q[i] <= rb;
            end
        end
        if (i < 16) begin : gData
            assign dataSec[i*8 +: 8] = rxBuf_q[i+10];
        end
    end

    always_comb begin
        unique case (rxBuf_q[6])
            spf_pkg::CMD_RETX_LIST: kind = spf_pkg::CMD_LIST;
            spf_pkg::CMD_RETX_RANGE: kind = spf_pkg::CMD_RANGE;
            spf_pkg::CMD_CALIB: kind = spf_pkg::CMD_CAL;
            default: kind = spf_pkg::CMD_UNKNOWN;
        endcase
    end

    // Command is offered only when the CRC over the whole packet lands on zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmdValid <= 1'b0;
            cmdCrcBad <= 1'b0;
            cmd <= '0;
        end else begin
            cmdValid <= 1'b0;
            cmdCrcBad <= 1'b0;
            if (rxValid && rxSt_q == RX_BODY && rxIdx_q == spf_pkg::CMD_CRC_LAST) begin
                cmdValid <= (rxCrcNext == 16'h0000);
                cmdCrcBad <= (rxCrcNext != 16'h0000);
                if (rxCrcNext == 16'h0000) begin
                    cmd <= '{kind: kind, instId: {rxBuf_q[1], rxBuf_q[0]},
                             seconds: {rxBuf_q[5], rxBuf_q[4], rxBuf_q[3], rxBuf_q[2]},
                             pktType: rxBuf_q[6], channel: rxBuf_q[7],
                             spare: {rxBuf_q[9], rxBuf_q[8]}, data: dataSec};
                end
            end
        end
    end

    // Checks
    logic [15:0] pktBytes_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pktBytes_q <= 16'h0000;
        end else if (startPkt) begin
            pktBytes_q <= 16'h0001;
        end else if (emit) begin
            pktBytes_q <= pktBytes_q + 16'h0001;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence sPktEnd;
        emit && txSt_q == TX_CRC && idx_q == spf_pkg::CRC_LAST;
    endsequence
    sequence sSyncPair;
        rxValid && rxSt_q == RX_HUNT2 && rb == spf_pkg::SYNC_LO;
    endsequence

    // Count shows the bytes before the last CRC byte, so one short of the packet
    chk_pkt_length: assert property (sPktEnd |-> pktBytes_q == 16'd24 + 16'd17 * {8'h00, nBund_q})
        else $error("packet length wrong");
    chk_next_sync: assert property (sPktEnd |=> txSt_q == TX_SYNC && idx_q == 5'h00)
        else $error("no sync after crc");
    chk_crc_start: assert property (startPkt |=> crc_q == spf_pkg::crcByte(spf_pkg::CRC_INIT, spf_pkg::SYNC_HI))
        else $error("crc not restarted");
    chk_retx_type: assert property (emit && txSt_q == TX_HEAD && idx_q == 5'h00 && isData_q
        |-> raw == {2'b00, cur_q.retransmit, 5'h01})
        else $error("data type byte wrong");
    chk_filler_type: assert property (emit && txSt_q == TX_HEAD && idx_q == 5'h00 && !isData_q
        |-> raw == spf_pkg::TYPE_FILLER)
        else $error("filler type byte wrong");
    chk_null_pad: assert property (emit && txSt_q == TX_BODY && isData_q && pad_q && idx_q == 5'h00
        |-> raw == spf_pkg::TYPE_NULL)
        else $error("pad bundle not null");
    chk_sync_scramble: assert property (startPkt ##1 (txInReady && canEmit)
        |-> (raw ^ SCRAMBLE_VALUE) == (spf_pkg::SYNC_LO ^ SCRAMBLE_VALUE))
        else $error("second sync byte wrong");
    chk_rx_collect: assert property (sSyncPair |=> rxSt_q == RX_BODY && rxIdx_q == 5'h00)
        else $error("sync pair not taken");
    chk_crc_drop: assert property (cmdCrcBad |-> !cmdValid ##1 !cmdValid)
        else $error("bad crc command offered");
endmodule

//--- spf_site_model.sv
`timescale 1ns/1ps
module spf_site_model #(
    parameter int LEN = 76,
    parameter logic [7:0] SCR = 8'hA5
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic txValid,
    output logic txReady,
    input wire logic [7:0] txData,
    output logic rxValid,
    output logic [7:0] rxData
);
    logic [8*LEN-1:0] cur;
    logic [8*LEN-1:0] lastFill;
    logic [8*LEN-1:0] pktQ[$];
    logic [7:0] b;
    int idx = 0;
    int fillCount = 0;
    int badCount = 0;

    function automatic logic [15:0] crcOf(input logic [8*LEN-1:0] p, input int n);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 0; i < n; i++) begin
            c = c ^ {8'h00, p[8*i+:8]};
            for (int j = 0; j < 8; j++) begin
                c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
            end
        end
        return c;
    endfunction

    initial begin
        txReady = 1'b0;
        rxValid = 1'b0;
        rxData = 8'h00;
    end

    // Random stalls so the framer's buffer sees back-pressure
    always @(posedge clk) begin
        txReady <= ($urandom % 4) != 0;
        if (rst_n && txValid && txReady) begin
            b = txData ^ SCR;
            cur[8*idx+:8] = b;
            if ((idx == 0 && b != 8'hAA) || (idx == 1 && b != 8'hBB)) begin
                idx = 0;
            end else if (idx == LEN - 1) begin
                idx = 0;
                if (cur[8*LEN-1-:16] != crcOf(cur, LEN - 2)) begin
                    badCount++;
                end else if ((cur[55:48] & 8'hDF) == 8'h09) begin
                    fillCount++;
                    lastFill = cur;
                end else begin
                    pktQ.push_back(cur);
                end
            end else begin
                idx++;
            end
        end
    end

    // Whole 30-byte command, optional junk ahead of the sync word
    task automatic sendCmd(input logic [207:0] body, input logic bad, input logic junk);
        logic [239:0] p;
        p = {16'h0000, body, 16'hBBAA};
        p[239-:16] = crcOf((8*LEN)'(p), 28) ^ {15'h0000, bad};
        for (int i = junk ? -2 : 0; i < 30; i++) begin
            rxValid <= 1'b1;
            rxData <= (i < 0 ? (i == -2 ? 8'hAA : 8'h11) : p[8*i+:8]) ^ SCR;
            @(posedge clk);
        end
        rxValid <= 1'b0;
    endtask
endmodule

//--- seismic_packet_framer_tb_top.sv
`timescale 1ns/1ps
module seismic_packet_framer_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hdrValid = 1'b0;
    logic bunValid = 1'b0;
    logic bunLast = 1'b0;
    logic [7:0] bunData = 8'h00;
    spf_pkg::spf_hdr_s hdr = '0;
    logic hdrReady, bunReady, txValid, txReady, rxValid, cmdValid, cmdCrcBad, bundleBad, rateBad;
    logic [7:0] txData, rxData;
    spf_pkg::spf_cmd_s cmd, cmdSeen;
    logic [7:0] srcQ[$];
    logic [7:0] types[6] = '{8'h01, 8'h02, 8'h06, 8'h07, 8'h01, 8'h02};
    logic [223:0] rnd;
    int errCount = 0;
    int samplesChecked = 0;
    int cycles = 0;
    int cmdCount = 0;
    int crcBadCount = 0;
    int rateBadCount = 0;
    int bunBadCount = 0;

    initial begin
        forever #10 clk = ~clk;
    end

    // Even bundle count, framer must round it up to three
    spf_framer dut (.clk(clk), .rst_n(rst_n), .bundleCount(8'h02), .hdrValid(hdrValid), .hdrReady(hdrReady),
        .hdr(hdr), .bunValid(bunValid), .bunReady(bunReady), .bunData(bunData), .bunLast(bunLast),
        .txValid(txValid), .txReady(txReady), .txData(txData), .rxValid(rxValid), .rxData(rxData),
        .cmdValid(cmdValid), .cmd(cmd), .cmdCrcBad(cmdCrcBad), .bundleBad(bundleBad), .rateBad(rateBad));
    spf_site_model #(.LEN(76)) site (.clk(clk), .rst_n(rst_n), .txValid(txValid), .txReady(txReady),
        .txData(txData), .rxValid(rxValid), .rxData(rxData));

    task automatic finishTest();
        $display("Summary: %0d compared, %0d wrong", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [607:0] seen, input logic [607:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cmdValid === 1'b1) begin
            cmdCount++;
            cmdSeen = cmd;
        end
        crcBadCount += int'(cmdCrcBad === 1'b1);
        rateBadCount += int'(rateBad === 1'b1);
        bunBadCount += int'(bundleBad === 1'b1);
        if (cycles == 20000) begin
            errCount++;
            finishTest();
        end
    end

    // Bundle source, byte held until taken
    always @(posedge clk) begin
        if (bunValid && bunReady) begin
            void'(srcQ.pop_front());
        end
        bunValid <= srcQ.size() > 0;
        bunData <= srcQ.size() > 0 ? srcQ[0] : 8'h00;
        bunLast <= srcQ.size() == 1;
    end

    function automatic logic [607:0] expPkt(spf_pkg::spf_hdr_s h, logic [407:0] d, int n);
        logic [607:0] e;
        e = '0;
        e[47:0] = {h.oldest, 16'hBBAA};
        e[183:48] = {h.firstSample, h.rateCode, h.channel, h.seqNum, h.modelType, h.serial, h.subSeconds,
            h.seconds, 2'b00, h.retransmit, 5'h01};
        for (int i = 0; i < 51; i++) begin
            e[184+8*i+:8] = i < n ? d[8*i+:8] : (i % 17 == 0 ? 8'h09 : spf_pkg::FILL_DEFAULT);
        end
        e[607:592] = site.crcOf(e, 74);
        return e;
    endfunction

    function automatic spf_pkg::spf_cmd_s expCmd(logic [207:0] b);
        spf_pkg::spf_cmd_e k;
        case (b[55:48])
            8'h01: k = spf_pkg::CMD_LIST;
            8'h02: k = spf_pkg::CMD_RANGE;
            8'h06: k = spf_pkg::CMD_CAL;
            default: k = spf_pkg::CMD_UNKNOWN;
        endcase
        return {k, b[15:0], b[47:16], b[55:48], b[63:56], b[79:64], b[207:80]};
    endfunction

    task automatic dataPkt(input logic [4:0] rate, input int n);
        spf_pkg::spf_hdr_s h;
        logic [407:0] d;
        rnd = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
        h = rnd[160:0];
        h.rateCode = rate;
        for (int i = 0; i < 51; i++) begin
            d[8*i+:8] = 8'($urandom);
        end
        for (int j = 0; j < 12; j++) begin
            if (d[136*(j/4)+2*(j%4)+:2] == 2'b00) begin
                d[136*(j/4)+2*(j%4)+:2] = 2'b10;
            end
        end
        if (rate == 5'h09) begin
            d[7:0] = 8'hC0;
        end
        if (rate == 5'h03) begin
            d[7:0] = 8'h55;
        end
        for (int i = 0; i < n; i++) begin
            srcQ.push_back(d[8*i+:8]);
        end
        hdr <= h;
        hdrValid <= 1'b1;
        for (int w = 0; w < 3000; w++) begin
            @(negedge clk);
            if (hdrReady === 1'b1) break;
        end
        @(posedge clk);
        hdrValid <= 1'b0;
        for (int w = 0; w < 3000 && site.pktQ.size() == 0; w++) @(posedge clk);
        if (site.pktQ.size() == 0) site.pktQ.push_back('x);
        check("data packet", site.pktQ.pop_front(), expPkt(h, d, n));
        $display("Test data packet rate %0d done", rate);
    endtask

    initial begin
        logic [207:0] body;
        void'($urandom(81));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int w = 0; w < 3000 && site.fillCount == 0; w++) @(posedge clk);
        check("filler type", 608'(site.lastFill[55:48]), 608'(8'h09));
        check("filler byte", 608'(site.lastFill[63:56]), 608'(spf_pkg::FILL_DEFAULT));
        $display("Test filler done");
        for (int r = 0; r < 18; r++) begin
            dataPkt(5'(r), r == 5 ? 22 : 51);
        end
        check("rate flags", 608'(rateBadCount), 608'(2));
        check("bundle flags", 608'(bunBadCount), 608'(1));
        check("bad crc packets", 608'(site.badCount), 608'(0));
        for (int k = 0; k < 6; k++) begin
            rnd = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
            body = rnd[207:0];
            body[55:48] = types[k];
            if (k == 2) begin
                body[63:56] = 8'h05;
                body[207:112] = {16'h0000, 16'h003C, 32'h4020_0000, 32'h3F80_0000};
            end
            site.sendCmd(body, k == 5, k == 4);
            repeat (4) @(posedge clk);
            check("command pulses", 608'({cmdCount, crcBadCount}), 608'({k < 5 ? k + 1 : 5, int'(k == 5)}));
            if (k < 5) check("command fields", 608'(cmdSeen), 608'(expCmd(body)));
            $display("Test command %0d done", k);
        end
        finishTest();
    end
endmodule
